// ---- dv/modem_baud_props.sv ----
// Purpose: port checker for modem_baud
// Assumes: one slave, hready_in tied to hreadyout_out
// Notes: bound at the foot of this file
`timescale 1ns/100ps
module modem_baud_props (
    input wire logic ref_clk_in,
    input wire logic rst_n_in,
    input wire logic hsel_in,
    input wire logic [7:0] haddr_in,
    input wire logic [1:0] htrans_in,
    input wire logic hwrite_in,
    input wire logic [31:0] hwdata_in,
    input wire logic hready_in,
    input wire logic [31:0] hrdata_out,
    input wire logic hreadyout_out,
    input wire logic clear_to_send_n_in,
    input wire logic set_ready_n_in,
    input wire logic ring_n_in,
    input wire logic carrier_detect_n_in,
    input wire logic terminal_ready_n_out,
    input wire logic request_to_send_n_out,
    input wire logic user_output_a_n_out,
    input wire logic user_output_b_n_out,
    input wire logic serial_output_out,
    input wire logic tx_shift_in,
    input wire logic receive_shift_register_in_out,
    input wire logic rx_irq_src_in,
    input wire logic tx_irq_src_in,
    input wire logic rx_irq_out,
    input wire logic tx_irq_out,
    input wire logic loopback_out
);
    // ****************************************
    // properties
    // ****************************************
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (!rst_n_in);
    logic [3:0] pins;
    logic [3:0] outs;
    logic [3:0] calm_r;
    assign pins = {carrier_detect_n_in, ring_n_in, set_ready_n_in, clear_to_send_n_in};
    assign outs = {user_output_b_n_out, user_output_a_n_out, request_to_send_n_out,
        terminal_ready_n_out};
    // levels are only compared once the pin synchronisers have settled
    always_ff @(posedge ref_clk_in) begin
        if (!rst_n_in || !$stable(pins)) calm_r <= 4'h0;
        else if (calm_r != 4'hf) calm_r <= calm_r + 4'h1;
    end
    sequence s_take(w, a);
        hsel_in && hready_in && htrans_in[1] && hwrite_in == w && haddr_in[7:2] == a;
    endsequence
    sequence s_wait;
        !hreadyout_out ##1 hreadyout_out;
    endsequence
    property p_ctl_drive;
        logic [4:0] v;
        s_take(1'b1, 6'h00) ##1 (1'b1, v = hwdata_in[4:0]) |=> (v[4] || outs == ~v[3:0]);
    endproperty
    a_ctl_drive: assert property (p_ctl_drive) else $error("modem outputs wrong");
    property p_loop_pins;
        loopback_out |-> outs == 4'hf;
    endproperty
    a_loop_pins: assert property (p_loop_pins) else $error("pins active in loop");
    property p_loop_serial_output;
        loopback_out && $past(loopback_out) |-> serial_output_out;
    endproperty
    a_loop_serial_output: assert property (p_loop_serial_output) else $error("serial out low in loop");
    property p_loop_path;
        loopback_out && $past(loopback_out) |-> receive_shift_register_in_out == $past(tx_shift_in);
    endproperty
    a_loop_path: assert property (p_loop_path) else $error("loop path broken");
    property p_irq_gate;
        (!rx_irq_out || rx_irq_src_in) && (!tx_irq_out || tx_irq_src_in);
    endproperty
    a_irq_gate: assert property (p_irq_gate) else $error("irq without source");
    property p_ctl_zero;
        s_take(1'b0, 6'h00) |=> s_wait ##0 hrdata_out[31:5] == 27'h0;
    endproperty
    a_ctl_zero: assert property (p_ctl_zero) else $error("control high bits set");
    property p_stat_lvl;
        logic [3:0] v;
        (s_take(1'b0, 6'h01) ##0 (!loopback_out && calm_r > 4'h8), v = ~pins)
            |=> s_wait ##0 (loopback_out || hrdata_out[7:4] == v);
    endproperty
    a_stat_lvl: assert property (p_stat_lvl) else $error("status levels wrong");
    property p_wr_fast;
        s_take(1'b1, haddr_in[7:2]) |=> hreadyout_out;
    endproperty
    a_wr_fast: assert property (p_wr_fast) else $error("write stalled");
endmodule
bind modem_baud modem_baud_props modem_baud_props_i (.*);

// ---- dv/modem_peer.sv ----
// Purpose: modem model driving the four active-low status pins
// Assumes: levels only, no handshake with the block
// Notes: lag_in sets how slowly a requested level reaches the pin
`timescale 1ns/100ps
module modem_peer (
    input wire logic clk_in,
    input wire logic [3:0] want_in,
    input wire logic [3:0] lag_in,
    output logic [3:0] pin_n_out = 4'hf
);
    logic [3:0] cnt_r = 4'h0;
    always @(posedge clk_in) begin
        if (want_in == pin_n_out) cnt_r <= 4'h0;
        else if (cnt_r >= lag_in) pin_n_out <= want_in;
        else cnt_r <= cnt_r + 4'h1;
    end
endmodule

// ---- dv/uart_modem_ctrl_baud_gen_tb.sv ----
// Purpose: register-level test of modem_baud
// Assumes: bus tasks issue one transfer at a time
// Notes: pin changes are given 20 cycles to pass the synchronisers
`timescale 1ns/100ps
module uart_modem_ctrl_baud_gen_tb;
    localparam logic [7:0] MC = modem_baud_pkg::OFS_MODEM_CONTROL;
    localparam logic [7:0] MS = modem_baud_pkg::OFS_MODEM_STATUS;
    localparam logic [7:0] LC = modem_baud_pkg::OFS_LINE_CONTROL;
    localparam logic [7:0] IE = modem_baud_pkg::OFS_INTERRUPT_ENABLE;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic hsel = 1'b0;
    logic [7:0] haddr = 8'h00;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic [31:0] rd;
    logic hready;
    logic [3:0] want = 4'hf;
    logic [3:0] lag = 4'h0;
    logic [3:0] pin_n;
    logic [3:0] out_n;
    logic serial_input = 1'b1;
    logic txs = 1'b1;
    logic rx_src = 1'b0;
    logic tx_src = 1'b0;
    logic serial_output, receive_shift_register, rx_irq, tx_irq, m_irq, tick, loop, hresp;
    int n_errors = 0;
    int n_tests = 0;
    modem_peer modem_peer_i (.clk_in(clk), .want_in(want), .lag_in(lag), .pin_n_out(pin_n));
    modem_baud modem_baud_i (.ref_clk_in(clk), .rst_n_in(rst_n), .hsel_in(hsel),
        .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2),
        .hwdata_in(hwdata), .hready_in(hready), .hrdata_out(hrdata), .hreadyout_out(hready),
        .hresp_out(hresp), .clear_to_send_n_in(pin_n[0]), .set_ready_n_in(pin_n[1]),
        .ring_n_in(pin_n[2]), .carrier_detect_n_in(pin_n[3]), .terminal_ready_n_out(out_n[0]),
        .request_to_send_n_out(out_n[1]), .user_output_a_n_out(out_n[2]),
        .user_output_b_n_out(out_n[3]), .serial_input_in(serial_input), .serial_output_out(serial_output),
        .tx_shift_in(txs), .receive_shift_register_in_out(receive_shift_register), .rx_irq_src_in(rx_src),
        .tx_irq_src_in(tx_src), .rx_irq_out(rx_irq), .tx_irq_out(tx_irq),
        .modem_irq_out(m_irq), .baud_tick_out(tick), .loopback_out(loop));
    // ****************************************
    // tasks and sequence
    // ****************************************
    initial begin
        forever #5 clk = ~clk;
    end
    task automatic conclude;
        $display("checks %0d errors %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic rdy;
        int k;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (hready !== 1'b1 && k < 50);
        if (k >= 50) begin
            n_errors++;
            conclude();
        end
    endtask
    task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
        haddr <= a;
        hwrite <= w;
        htrans <= 2'h2;
        rdy();
        htrans <= 2'h0;
        hwdata <= d;
        rdy();
        rd = hrdata;
    endtask
    task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            $display("Error %s expected %h seen %h", s, e, g);
            n_errors++;
        end
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] e, input string s);
        bus(a, 1'b0, 32'h0);
        chk(s, e, rd);
    endtask
    initial begin
        int c;
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        hsel <= 1'b1;
        bus(MC, 1'b1, 32'hef);
        rdchk(MC, 32'h0f, "control");
        chk("hresp", 32'h0, {31'h0, hresp});
        for (int i = 0; i < 4; i++) begin
            bus(MC, 1'b1, 32'h1 << i);
            @(posedge clk);
            chk("outputs", {28'h0, ~(4'h1 << i)}, {28'h0, out_n});
        end
        bus(IE, 1'b1, 32'h08);
        for (int i = 0; i < 4; i++) begin
            lag <= 4'(i);
            want[i] <= 1'b0;
            repeat (20) @(posedge clk);
            chk("irq", 32'(i != 2), {31'h0, m_irq});
            rdchk(MS, (i == 2 ? 32'h0 : 32'h1 << i) | (32'h10 << i), "status");
            repeat (2) @(posedge clk);
            chk("irq", 32'h0, {31'h0, m_irq});
            want[i] <= 1'b1;
            repeat (20) @(posedge clk);
            chk("irq", 32'h1, {31'h0, m_irq});
            rdchk(MS, 32'h1 << i, "status");
        end
        bus(MC, 1'b1, 32'h13);
        serial_input <= 1'b0;
        txs <= 1'b0;
        repeat (4) @(posedge clk);
        chk("loop", {26'h0, 4'hf, 1'b1, 1'b0}, {26'h0, out_n, serial_output, receive_shift_register});
        txs <= 1'b1;
        repeat (4) @(posedge clk);
        chk("loop rx", 32'h1, {31'h0, receive_shift_register});
        bus(MS, 1'b0, 32'h0);
        rdchk(MS, 32'h30, "loop status");
        rx_src <= 1'b1;
        tx_src <= 1'b1;
        bus(IE, 1'b1, 32'h0b);
        @(posedge clk);
        chk("rx tx irq", 32'h3, {30'h0, rx_irq, tx_irq});
        bus(IE, 1'b1, 32'h08);
        @(posedge clk);
        chk("rx tx irq", 32'h0, {30'h0, rx_irq, tx_irq});
        bus(MC, 1'b1, 32'h0);
        bus(LC, 1'b1, 32'h80);
        bus(modem_baud_pkg::OFS_BAUD_DIVISOR_HIGH, 1'b1, 32'h0);
        for (int j = 1; j >= 0; j--) begin
            begin
                bus(modem_baud_pkg::OFS_BAUD_DIVISOR_LOW, 1'b1, j ? 32'd12 : 32'd3);
                c = 0;
                repeat (12 * (j ? 12 : 3) + 1) begin
                    @(posedge clk);
                    c += int'(tick === 1'b1);
                end
                chk("ticks", 32'd12, 32'(c));
            end
        end
        rdchk(modem_baud_pkg::OFS_BAUD_DIVISOR_LOW, 32'd3, "divisor");
        bus(LC, 1'b1, 32'h0);
        rdchk(modem_baud_pkg::OFS_BAUD_DIVISOR_LOW, 32'h0, "hidden divisor");
        rdchk(8'h1c, 32'h0, "unmapped");
        conclude();
    end
endmodule

// ---- include/modem_baud_pkg.sv ----
// Purpose: constants shared by the modem-control and baud-generator block
// Assumes: 32-bit AHB-Lite register port, one register per aligned word
// Notes: all offsets are byte addresses within the slave's window
package modem_baud_pkg;
    // ****************************************
    // register byte offsets
    // ****************************************
    localparam logic [7:0] OFS_MODEM_CONTROL = 8'h00;
    localparam logic [7:0] OFS_MODEM_STATUS = 8'h04;
    localparam logic [7:0] OFS_BAUD_DIVISOR_LOW = 8'h08;
    localparam logic [7:0] OFS_BAUD_DIVISOR_HIGH = 8'h0c;
    localparam logic [7:0] OFS_LINE_CONTROL = 8'h10;
    localparam logic [7:0] OFS_INTERRUPT_ENABLE = 8'h14;

    // ****************************************
    // field positions
    // ****************************************
    localparam int MCR_TERMINAL_READY = 0;
    localparam int MCR_REQUEST_TO_SEND = 1;
    localparam int MCR_USER_A = 2;
    localparam int MCR_USER_B = 3;
    localparam int MCR_LOOPBACK = 4;
    localparam int LCR_DIVISOR_ACCESS = 7;
    localparam int IER_RX = 0;
    localparam int IER_TX = 1;
    localparam int IER_MODEM = 3;
    // modem input order inside the 4-bit vectors: cts, dsr, ri, dcd
    localparam int IN_CTS = 0;
    localparam int IN_DSR = 1;
    localparam int IN_RI = 2;
    localparam int IN_DCD = 3;
    localparam int IN_SIN = 4;

    // ****************************************
    // reset values
    // ****************************************
    localparam logic [4:0] MODEM_CONTROL_RST = 5'h00;
    localparam logic [3:0] INTERRUPT_ENABLE_RST = 4'h0;
    localparam logic [7:0] DIVISOR_RST = 8'h00;
    localparam logic [4:0] PIN_IDLE = 5'h1f;
endpackage

// ---- rtl/modem_baud.sv ----
// Purpose: modem control/status, local loopback and 16x baud generator
// Assumes: single AHB-Lite master, word transfers only, one clock
// Notes: reads take one wait state so a preceding write is always seen
`timescale 1ns/100ps

module modem_baud (
    input wire logic ref_clk_in,
    input wire logic rst_n_in,
    input wire logic hsel_in,
    input wire logic [7:0] haddr_in,
    input wire logic [1:0] htrans_in,
    input wire logic hwrite_in,
    input wire logic [2:0] hsize_in,
    input wire logic [31:0] hwdata_in,
    input wire logic hready_in,
    output logic [31:0] hrdata_out,
    output logic hreadyout_out,
    output logic hresp_out,
    input wire logic clear_to_send_n_in,
    input wire logic set_ready_n_in,
    input wire logic ring_n_in,
    input wire logic carrier_detect_n_in,
    output logic terminal_ready_n_out,
    output logic request_to_send_n_out,
    output logic user_output_a_n_out,
    output logic user_output_b_n_out,
    input wire logic serial_input_in,
    output logic serial_output_out,
    input wire logic tx_shift_in,
    output logic receive_shift_register_in_out,
    input wire logic rx_irq_src_in,
    input wire logic tx_irq_src_in,
    output logic rx_irq_out,
    output logic tx_irq_out,
    output logic modem_irq_out,
    output logic baud_tick_out,
    output logic loopback_out
);
    // ****************************************
    // state
    // ****************************************
    typedef struct packed {
        logic [4:0] modem_control;
        logic [3:0] interrupt_enable_register;
        logic dab;
        logic [7:0] div_lo;
        logic [7:0] div_hi;
        logic [15:0] cnt;
        logic tick;
        logic [4:0] s1;
        logic [4:0] s2;
        logic [4:0] s3;
        logic [4:0] filt;
        logic [3:0] act_prev;
        logic [3:0] delta;
        logic wr_pend;
        logic rd_wait;
        logic [7:0] addr;
        logic [31:0] rdata;
        logic rx_bit;
        logic tx_bit;
    } state_t;

    state_t st_r;
    state_t st_nxt;

    // word-aligned address match inside the window
    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        hit = (a[7:2] == ofs[7:2]);
    endfunction

    logic addr_phase;
    logic loop;
    logic [3:0] act;
    logic [3:0] chg;
    logic [15:0] divisor;
    logic rd_status;

    assign loop = st_r.modem_control[modem_baud_pkg::MCR_LOOPBACK];
    assign divisor = {st_r.div_hi, st_r.div_lo};
    assign addr_phase = hsel_in & hready_in & htrans_in[1];
    assign rd_status = st_r.rd_wait & hit(st_r.addr, modem_baud_pkg::OFS_MODEM_STATUS);

    // active-high view of the modem inputs, or the looped control bits
    always_comb begin
        if (loop) begin
            act[modem_baud_pkg::IN_CTS] = st_r.modem_control[modem_baud_pkg::MCR_REQUEST_TO_SEND];
            act[modem_baud_pkg::IN_DSR] = st_r.modem_control[modem_baud_pkg::MCR_TERMINAL_READY];
            act[modem_baud_pkg::IN_RI] = st_r.modem_control[modem_baud_pkg::MCR_USER_A];
            act[modem_baud_pkg::IN_DCD] = st_r.modem_control[modem_baud_pkg::MCR_USER_B];
        end else begin
            act = ~st_r.filt[3:0];
        end
        chg[modem_baud_pkg::IN_CTS] = act[0] ^ st_r.act_prev[0];
        chg[modem_baud_pkg::IN_DSR] = act[1] ^ st_r.act_prev[1];
        // pin going low to high is the active level falling
        chg[modem_baud_pkg::IN_RI] = st_r.act_prev[2] & ~act[2];
        chg[modem_baud_pkg::IN_DCD] = act[3] ^ st_r.act_prev[3];
    end

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        st_nxt = st_r;
        st_nxt.tick = 1'b0;

        // three-stage synchronisers; the level moves once stages 2 and 3 agree
        st_nxt.s1 = {serial_input_in, carrier_detect_n_in, ring_n_in,
                     set_ready_n_in, clear_to_send_n_in};
        st_nxt.s2 = st_r.s1;
        st_nxt.s3 = st_r.s2;
        for (int i = 0; i < 5; i++) begin
            if (st_r.s2[i] == st_r.s3[i]) begin
                st_nxt.filt[i] = st_r.s3[i];
            end
        end

        // change flags: a new change wins over a clearing read
        st_nxt.act_prev = act;
        st_nxt.delta = (rd_status ? 4'h0 : st_r.delta) | chg;

        // serial path; the transmitter's own bit loops back to the receiver
        st_nxt.tx_bit = loop ? 1'b1 : tx_shift_in;
        st_nxt.rx_bit = loop ? tx_shift_in : st_r.filt[modem_baud_pkg::IN_SIN];

        // baud counter: a zero divisor holds the generator still
        if (divisor != 16'h0000) begin
            if (st_r.cnt <= 16'h0001) begin
                st_nxt.tick = 1'b1;
                st_nxt.cnt = divisor;
            end else begin
                st_nxt.cnt = st_r.cnt - 16'h0001;
            end
        end else begin
            st_nxt.cnt = 16'h0000;
        end

        // write data phase
        st_nxt.wr_pend = 1'b0;
        if (st_r.wr_pend) begin
            if (hit(st_r.addr, modem_baud_pkg::OFS_MODEM_CONTROL)) begin
                st_nxt.modem_control = hwdata_in[4:0];
            end
            if (hit(st_r.addr, modem_baud_pkg::OFS_LINE_CONTROL)) begin
                st_nxt.dab = hwdata_in[modem_baud_pkg::LCR_DIVISOR_ACCESS];
            end
            if (hit(st_r.addr, modem_baud_pkg::OFS_INTERRUPT_ENABLE) && !st_r.dab) begin
                st_nxt.interrupt_enable_register = hwdata_in[3:0];
            end
            if (st_r.dab && hit(st_r.addr, modem_baud_pkg::OFS_BAUD_DIVISOR_LOW)) begin
                st_nxt.div_lo = hwdata_in[7:0];
                // reload at once so the old count does not delay the new rate
                st_nxt.cnt = {st_r.div_hi, hwdata_in[7:0]};
                st_nxt.tick = 1'b0;
            end
            if (st_r.dab && hit(st_r.addr, modem_baud_pkg::OFS_BAUD_DIVISOR_HIGH)) begin
                st_nxt.div_hi = hwdata_in[7:0];
                st_nxt.cnt = {hwdata_in[7:0], st_r.div_lo};
                st_nxt.tick = 1'b0;
            end
        end

        // read data: formed one cycle after the address phase
        st_nxt.rd_wait = 1'b0;
        if (st_r.rd_wait) begin
            st_nxt.rdata = 32'h0000_0000;
            if (hit(st_r.addr, modem_baud_pkg::OFS_MODEM_CONTROL)) begin
                st_nxt.rdata = {27'h0, st_r.modem_control};
            end
            if (hit(st_r.addr, modem_baud_pkg::OFS_MODEM_STATUS)) begin
                st_nxt.rdata = {24'h0, act, st_r.delta};
            end
            if (st_r.dab && hit(st_r.addr, modem_baud_pkg::OFS_BAUD_DIVISOR_LOW)) begin
                st_nxt.rdata = {24'h0, st_r.div_lo};
            end
            if (st_r.dab && hit(st_r.addr, modem_baud_pkg::OFS_BAUD_DIVISOR_HIGH)) begin
                st_nxt.rdata = {24'h0, st_r.div_hi};
            end
            if (hit(st_r.addr, modem_baud_pkg::OFS_LINE_CONTROL)) begin
                st_nxt.rdata = {24'h0, st_r.dab, 7'h00};
            end
            if (!st_r.dab && hit(st_r.addr, modem_baud_pkg::OFS_INTERRUPT_ENABLE)) begin
                st_nxt.rdata = {28'h0, st_r.interrupt_enable_register};
            end
        end

        // address phase
        if (addr_phase) begin
            st_nxt.addr = haddr_in;
            st_nxt.wr_pend = hwrite_in;
            st_nxt.rd_wait = ~hwrite_in;
        end
    end

    // ****************************************
    // registers
    // ****************************************
    always_ff @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            st_r <= '0;
            st_r.modem_control <= modem_baud_pkg::MODEM_CONTROL_RST;
            st_r.interrupt_enable_register <= modem_baud_pkg::INTERRUPT_ENABLE_RST;
            st_r.div_lo <= modem_baud_pkg::DIVISOR_RST;
            st_r.div_hi <= modem_baud_pkg::DIVISOR_RST;
            st_r.s1 <= modem_baud_pkg::PIN_IDLE;
            st_r.s2 <= modem_baud_pkg::PIN_IDLE;
            st_r.s3 <= modem_baud_pkg::PIN_IDLE;
            st_r.filt <= modem_baud_pkg::PIN_IDLE;
            st_r.rx_bit <= 1'b1;
            st_r.tx_bit <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign hrdata_out = st_r.rdata;
    assign hreadyout_out = ~st_r.rd_wait;
    assign hresp_out = 1'b0;

    // pins go inactive high in loopback; the bits still feed the status
    assign terminal_ready_n_out = ~st_r.modem_control[modem_baud_pkg::MCR_TERMINAL_READY] | loop;
    assign request_to_send_n_out = ~st_r.modem_control[modem_baud_pkg::MCR_REQUEST_TO_SEND] | loop;
    assign user_output_a_n_out = ~st_r.modem_control[modem_baud_pkg::MCR_USER_A] | loop;
    assign user_output_b_n_out = ~st_r.modem_control[modem_baud_pkg::MCR_USER_B] | loop;

    assign serial_output_out = st_r.tx_bit;
    assign receive_shift_register_in_out = st_r.rx_bit;
    assign loopback_out = loop;
    assign baud_tick_out = st_r.tick;

    // interrupt sources stay live in loopback, always behind their enables
    assign rx_irq_out = rx_irq_src_in & st_r.interrupt_enable_register[modem_baud_pkg::IER_RX];
    assign tx_irq_out = tx_irq_src_in & st_r.interrupt_enable_register[modem_baud_pkg::IER_TX];
    assign modem_irq_out = (|st_r.delta) & st_r.interrupt_enable_register[modem_baud_pkg::IER_MODEM];
endmodule
